/* wakeup_cfg_pkg.sv */
// Constants, field layout and carriers for the wake-up and sleep power block
package wakeup_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [31:0] USB_CTRL_ADDR    = 32'h4004_8198;
  localparam logic [31:0] USB_STAT_ADDR    = 32'h4004_819C;
  localparam logic [31:0] PIN_WAKE_ADDR    = 32'h4004_8204;
  localparam logic [31:0] PERIPH_WAKE_ADDR = 32'h4004_8214;
  localparam logic [31:0] SLEEP_CFG_ADDR   = 32'h4004_8230;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int OVERRIDE_BIT  = 0;
  localparam int POLARITY_BIT  = 1;
  localparam int LEVEL_BIT     = 0;
  localparam int PIN_WAKE_W    = 8;
  localparam int WINDOWED_WATCHDOG_BIT      = 12;
  localparam int BOD_BIT       = 13;
  localparam int USB_BIT       = 19;
  localparam int GRP_A_BIT     = 20;
  localparam int GRP_B_BIT     = 21;
  localparam int BOD_OFF_BIT   = 3;
  localparam int WDOSC_OFF_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic        OVERRIDE_RST    = 1'b0;
  localparam logic        POLARITY_RST    = 1'b0;
  localparam logic [7:0]  PIN_WAKE_RST    = 8'h00;
  localparam logic        PERIPH_WAKE_RST = 1'b0;
  localparam logic        BOD_OFF_RST     = 1'b1;
  localparam logic        WDOSC_OFF_RST   = 1'b1;
  // Reserved sleep bits 2:0 and 5:4 read back as ones
  localparam logic [31:0] SLEEP_RSVD_VAL  = 32'h0000_0037;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [7:0] pin;
    logic       windowed_watchdog;
    logic       brownout_detector;
    logic       grp_a;
    logic       grp_b;
  } irq_in_s;

  typedef struct packed {
    logic [7:0] pin;
    logic       windowed_watchdog;
    logic       brownout_detector;
    logic       usb;
    logic       grp_a;
    logic       grp_b;
  } wake_src_s;

  typedef struct packed {
    logic bod_off;
    logic wdosc_off;
  } sleep_pd_s;

endpackage

/* wakeup_source_power_config.sv */
// Wake-up source enables, USB clock request control and sleep power choices
//
// What this block does
// - Override bit 0 forces the USB clock request high; 0 leaves hardware control.
// - Polarity bit 1 picks falling (0) or rising (1) request edge for wake.
// - Status register bit 0 shows request level; read-only, writes ignored.
// - Eight pin interrupt wake enables at bits 0 to 7, reset disabled.
// - A source wakes only if wake-enabled and enabled in nested_irq_controller.
// - Bit 12 enables windowed watchdog wake, reset disabled.
// - Bit 13 enables brown-out detector wake, reset disabled.
// - Bit 19 enables USB clock request edge wake, reset disabled.
// - Bits 20 and 21 enable the two port group wakes, reset disabled.
// - Entering low power copies sleep power-down bits into run_power_config.
// - Sleep bit 3 powers brown-out detector down in low power; resets 1.
// - In low power all analog blocks forced off except those two.
// - Watchdog lock overrides the oscillator sleep power-down value.
// - Sleep bit 6 powers watchdog oscillator down in low power; resets 1.
`timescale 1ns/1ps

module wakeup_source_power_config
  import wakeup_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,

  // Register port
  input  wire logic [31:0] ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,

  // USB clock request
  input  wire logic        NEED_CLOCK,
  output logic             USB_CLK_REQ,

  // Wake sources and controller enables
  input  wire irq_in_s     IRQ_IN,
  input  wire wake_src_s   IRQ_EN,
  input  wire logic        LOW_POWER,
  input  wire logic        WDT_LOCK,
  output logic             WAKE_REQ,

  // Power-down handover
  output logic             PD_LOAD,
  output sleep_pd_s        PD_CFG,
  output logic             ANALOG_FORCE_OFF
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding

  // Full byte addresses are compared; a near miss is simply unmapped
  function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_a);
    hit = (a == ref_a);
  endfunction

  wire logic wr_ctrl   = WR & hit(ADDR, USB_CTRL_ADDR);
  wire logic wr_pin    = WR & hit(ADDR, PIN_WAKE_ADDR);
  wire logic wr_periph = WR & hit(ADDR, PERIPH_WAKE_ADDR);
  wire logic wr_sleep  = WR & hit(ADDR, SLEEP_CFG_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic       override_reg;
  logic       polarity_reg;
  logic [7:0] pin_wake_reg;
  logic       windowed_watchdog_wake_reg;
  logic       bod_wake_reg;
  logic       usb_wake_reg;
  logic       grp_a_wake_reg;
  logic       grp_b_wake_reg;
  logic       bod_off_reg;
  logic       wdosc_off_reg;

  // Clock request control
  always_ff @(posedge CLK) begin
    if (SRST) begin
      override_reg <= OVERRIDE_RST;
      polarity_reg <= POLARITY_RST;
    end else if (wr_ctrl) begin
      override_reg <= WDATA[OVERRIDE_BIT];
      polarity_reg <= WDATA[POLARITY_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      pin_wake_reg <= PIN_WAKE_RST;
    end else if (wr_pin) begin
      pin_wake_reg <= WDATA[PIN_WAKE_W-1:0];
    end
  end

  // Peripheral wake enables; the bits between them are reserved
  always_ff @(posedge CLK) begin
    if (SRST) begin
      windowed_watchdog_wake_reg  <= PERIPH_WAKE_RST;
      bod_wake_reg   <= PERIPH_WAKE_RST;
      usb_wake_reg   <= PERIPH_WAKE_RST;
      grp_a_wake_reg <= PERIPH_WAKE_RST;
      grp_b_wake_reg <= PERIPH_WAKE_RST;
    end else if (wr_periph) begin
      windowed_watchdog_wake_reg  <= WDATA[WINDOWED_WATCHDOG_BIT];
      bod_wake_reg   <= WDATA[BOD_BIT];
      usb_wake_reg   <= WDATA[USB_BIT];
      grp_a_wake_reg <= WDATA[GRP_A_BIT];
      grp_b_wake_reg <= WDATA[GRP_B_BIT];
    end
  end

  // Sleep choices reset to powered down
  always_ff @(posedge CLK) begin
    if (SRST) begin
      bod_off_reg   <= BOD_OFF_RST;
      wdosc_off_reg <= WDOSC_OFF_RST;
    end else if (wr_sleep) begin
      bod_off_reg   <= WDATA[BOD_OFF_BIT];
      wdosc_off_reg <= WDATA[WDOSC_OFF_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // USB clock request: synchroniser, override and wake edge

  logic need_meta_reg;
  logic need_sync_reg;
  logic req_level_reg;

  // NEED_CLOCK comes from the USB side's clock, so it passes two flops
  always_ff @(posedge CLK) begin
    if (SRST) begin
      need_meta_reg <= 1'b0;
      need_sync_reg <= 1'b0;
    end else begin
      need_meta_reg <= NEED_CLOCK;
      need_sync_reg <= need_meta_reg;
    end
  end

  // Effective request level as seen by the USB side
  wire logic req_level_next = need_sync_reg | override_reg;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      req_level_reg <= 1'b0;
    end else begin
      req_level_reg <= req_level_next;
    end
  end

  wire logic req_rise = req_level_next & ~req_level_reg;
  wire logic req_fall = ~req_level_next & req_level_reg;
  wire logic usb_edge = polarity_reg ? req_rise : req_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Wake request

  wake_src_s src;
  wake_src_s wen;
  wake_src_s armed;

  assign src.pin   = IRQ_IN.pin;
  assign src.windowed_watchdog  = IRQ_IN.windowed_watchdog;
  assign src.brownout_detector   = IRQ_IN.brownout_detector;
  assign src.usb   = usb_edge;
  assign src.grp_a = IRQ_IN.grp_a;
  assign src.grp_b = IRQ_IN.grp_b;

  assign wen.pin   = pin_wake_reg;
  assign wen.windowed_watchdog  = windowed_watchdog_wake_reg;
  assign wen.brownout_detector   = bod_wake_reg;
  assign wen.usb   = usb_wake_reg;
  assign wen.grp_a = grp_a_wake_reg;
  assign wen.grp_b = grp_b_wake_reg;

  // Per source: both this block and the interrupt controller must agree
  for (genvar s = 0; s < $bits(wake_src_s); s++) begin : g_arm
    assign armed[s] = src[s] & wen[s] & IRQ_EN[s];
  end

  wire logic wake_next = LOW_POWER & (|armed);

  ////////////////////////////////////////////////////////////////////////////
  // Sleep power handover

  logic low_power_d_reg;

  // Lock keeps the watchdog oscillator running for the watchdog
  wire logic wdosc_eff = wdosc_off_reg & ~WDT_LOCK;
  wire logic enter_lp  = LOW_POWER & ~low_power_d_reg;

  sleep_pd_s pd_next;
  assign pd_next.bod_off   = bod_off_reg;
  assign pd_next.wdosc_off = wdosc_eff;

  // Previous low-power level, for finding the entry edge
  always_ff @(posedge CLK) begin
    if (SRST) begin
      low_power_d_reg <= 1'b0;
    end else begin
      low_power_d_reg <= LOW_POWER;
    end
  end

  // One-cycle strobe that tells the run power register to take PD_CFG
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PD_LOAD <= 1'b0;
    end else begin
      PD_LOAD <= enter_lp;
    end
  end

  // Tracks the settings while awake, holds the copy taken on entry
  wire logic pd_track = enter_lp | ~LOW_POWER;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      PD_CFG <= '{bod_off: BOD_OFF_RST, wdosc_off: WDOSC_OFF_RST};
    end else if (pd_track) begin
      PD_CFG <= pd_next;
    end
  end

  // Analog blocks follow the mode, one cycle late like the copy
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ANALOG_FORCE_OFF <= 1'b0;
    end else begin
      ANALOG_FORCE_OFF <= LOW_POWER;
    end
  end

  // Registered so the power controller sees a clean level
  always_ff @(posedge CLK) begin
    if (SRST) begin
      WAKE_REQ <= 1'b0;
    end else begin
      WAKE_REQ <= wake_next;
    end
  end

  // Same timing as the status bit, which reads the twin flop
  always_ff @(posedge CLK) begin
    if (SRST) begin
      USB_CLK_REQ <= 1'b0;
    end else begin
      USB_CLK_REQ <= req_level_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // One select per register; an unmapped address selects none and reads 0
  wire logic sel_ctrl   = hit(ADDR, USB_CTRL_ADDR);
  wire logic sel_stat   = hit(ADDR, USB_STAT_ADDR);
  wire logic sel_pin    = hit(ADDR, PIN_WAKE_ADDR);
  wire logic sel_periph = hit(ADDR, PERIPH_WAKE_ADDR);
  wire logic sel_sleep  = hit(ADDR, SLEEP_CFG_ADDR);

  // Views of each register; bits without a field keep their reset value
  wire logic [31:0] ctrl_view   =
    (32'(override_reg) << OVERRIDE_BIT) |
    (32'(polarity_reg) << POLARITY_BIT);

  // Status has no write decode at all, so writes to it are lost
  wire logic [31:0] stat_view   = 32'(req_level_reg) << LEVEL_BIT;

  wire logic [31:0] pin_view    = 32'(pin_wake_reg);

  wire logic [31:0] periph_view =
    (32'(windowed_watchdog_wake_reg)  << WINDOWED_WATCHDOG_BIT)  |
    (32'(bod_wake_reg)   << BOD_BIT)   |
    (32'(usb_wake_reg)   << USB_BIT)   |
    (32'(grp_a_wake_reg) << GRP_A_BIT) |
    (32'(grp_b_wake_reg) << GRP_B_BIT);

  wire logic [31:0] sleep_view  =
    SLEEP_RSVD_VAL |
    (32'(bod_off_reg)   << BOD_OFF_BIT) |
    (32'(wdosc_off_reg) << WDOSC_OFF_BIT);

  wire logic [31:0] rd_mux      =
    ({32{sel_ctrl}}   & ctrl_view)   |
    ({32{sel_stat}}   & stat_view)   |
    ({32{sel_pin}}    & pin_view)    |
    ({32{sel_periph}} & periph_view) |
    ({32{sel_sleep}}  & sleep_view);

  // Read data stands for one cycle only, then returns to zero
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      RDATA <= rd_mux;
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

endmodule // wakeup_source_power_config

/* wakeup_source_power_config_assertions.sv */
// Port checks for the wake-up and sleep power block
`timescale 1ns/1ps

module wakeup_power_checker
  import wakeup_cfg_pkg::*;
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // Register port
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // USB request
  input wire logic        NEED_CLOCK,
  input wire logic        USB_CLK_REQ,
  // Wake
  input wire irq_in_s     IRQ_IN,
  input wire wake_src_s   IRQ_EN,
  input wire logic        LOW_POWER,
  input wire logic        WDT_LOCK,
  input wire logic        WAKE_REQ,
  // Power-down handover
  input wire logic        PD_LOAD,
  input wire sleep_pd_s   PD_CFG,
  input wire logic        ANALOG_FORCE_OFF
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);

  ////////////////////////////////////////////////////////////////////////////
  wake_idle_a: assert property (!LOW_POWER |=> !WAKE_REQ) else $error("wake out of sleep");
  pd_load_a: assert property ($rose(LOW_POWER) |=> PD_LOAD) else $error("no load");
  pd_pulse_a: assert property (PD_LOAD |=> !PD_LOAD) else $error("load too long");
  load_cause_a: assert property (PD_LOAD |-> $past(LOW_POWER) && !$past(LOW_POWER, 2))
    else $error("stray load");
  analog_off_a: assert property (ANALOG_FORCE_OFF == $past(LOW_POWER))
    else $error("analog force wrong");
  cfg_frozen_a: assert property (LOW_POWER && ANALOG_FORCE_OFF |=> $stable(PD_CFG))
    else $error("cfg moved in sleep");
  wdt_lock_a: assert property (!SRST && WDT_LOCK && !LOW_POWER |=> !PD_CFG.wdosc_off)
    else $error("lock ignored");
  usb_follow_a: assert property ($rose(NEED_CLOCK) |-> ##[2:4] USB_CLK_REQ)
    else $error("request not passed");
  stat_rsvd_a: assert property (RD && ADDR == USB_STAT_ADDR |=> RDATA[31:1] == '0)
    else $error("status reserved set");
  sleep_rsvd_a: assert property (RD && ADDR == SLEEP_CFG_ADDR |=> RDATA[5:0] ==? 6'b11?111)
    else $error("sleep reserved wrong");

  cover property (WAKE_REQ);
  cover property (PD_LOAD);
  cover property ($rose(USB_CLK_REQ));
endmodule // wakeup_power_checker

bind wakeup_source_power_config wakeup_power_checker u_chk (
  .CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .NEED_CLOCK, .USB_CLK_REQ, .IRQ_IN,
  .IRQ_EN, .LOW_POWER, .WDT_LOCK, .WAKE_REQ, .PD_LOAD, .PD_CFG, .ANALOG_FORCE_OFF
);

/* usb_pm_model.sv */
// Power controller and USB controller model for the far side
`timescale 1ns/1ps

module usb_pm_model (
  // Clock
  input  wire logic clk,
  // Bench requests
  input  wire logic sleep_want,
  input  wire logic clk_want,
  input  wire logic slow,
  // Block side
  output logic      low_power,
  output logic      need_clock
);
  logic want_dly;

  // Slow mode answers one cycle later
  always_ff @(posedge clk) begin
    want_dly   <= clk_want;
    need_clock <= slow ? want_dly : clk_want;
    low_power  <= sleep_want;
  end
endmodule // usb_pm_model

/* tb_wakeup_source_power_config.sv */
// Self-checking bench for the wake-up and sleep power block
`timescale 1ns/1ps

module tb_wakeup_source_power_config
  import wakeup_cfg_pkg::*;
;
  logic        clk, srst, wr, rd, sleep_want, clk_want, slow, wdt_lock;
  logic        need_clock, usb_clk_req, low_power, wake_req, pd_load, afo;
  logic [31:0] addr, wdata, rdata, v;
  irq_in_s     irq_in;
  wake_src_s   irq_en;
  sleep_pd_s   pd_cfg;
  int          fail_count, check_count;
  typedef struct {logic [31:0] a; bit w; logic [31:0] d; logic [31:0] e;} row_s;
  row_s rows[12] = '{
    '{USB_CTRL_ADDR, 0, 0, 0}, '{USB_STAT_ADDR, 0, 0, 0}, '{PIN_WAKE_ADDR, 0, 0, 0},
    '{PERIPH_WAKE_ADDR, 0, 0, 0}, '{SLEEP_CFG_ADDR, 0, 0, 32'h0000_007F},
    '{PIN_WAKE_ADDR, 1, 32'hFFFF_FF5A, 32'h0000_005A},
    '{PERIPH_WAKE_ADDR, 1, 32'hFFFF_FFFF, 32'h0038_3000},
    '{USB_CTRL_ADDR, 1, 32'hFFFF_FFFE, 32'h0000_0002},
    '{USB_STAT_ADDR, 1, 32'hFFFF_FFFF, 0}, '{SLEEP_CFG_ADDR, 1, 0, 32'h0000_0037},
    '{SLEEP_CFG_ADDR, 1, 32'hFFFF_FFFF, 32'h0000_007F}, '{32'h4004_8200, 1, '1, 0}};

  wakeup_source_power_config u_dut (
    .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .NEED_CLOCK(need_clock), .USB_CLK_REQ(usb_clk_req), .IRQ_IN(irq_in), .IRQ_EN(irq_en),
    .LOW_POWER(low_power), .WDT_LOCK(wdt_lock), .WAKE_REQ(wake_req), .PD_LOAD(pd_load),
    .PD_CFG(pd_cfg), .ANALOG_FORCE_OFF(afo));

  usb_pm_model u_far (.clk(clk), .sleep_want(sleep_want), .clk_want(clk_want), .slow(slow),
    .low_power(low_power), .need_clock(need_clock));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [31:0] a, d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] q);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Wake from the USB request is a pulse, so catch it over a window
  task automatic catch_wake(input logic exp, input string m);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1 seen = seen | wake_req;
    end
    chk({31'b0, seen}, {31'b0, exp}, m);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #50us;
    fail_count++;
    summarize();
  end
  initial begin
    {srst, wr, rd, sleep_want, clk_want, slow, wdt_lock} = 7'b1000000;
    addr = '0; wdata = '0; irq_in = '0; irq_en = '1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, v);
      chk(v, rows[i].e, "register");
    end
    $display("test registers done");
    @(posedge clk) wdt_lock <= 1'b1;
    wr_reg(SLEEP_CFG_ADDR, 32'h0000_0048);
    tick(2); chk(32'(pd_cfg), 2, "lock");
    @(posedge clk) sleep_want <= 1'b1;
    tick(2); chk({31'b0, pd_load}, 1, "load pulse");
    chk(32'(pd_cfg), 2, "loaded cfg");
    tick(1); chk({30'b0, afo, pd_load}, 2, "analog off");
    wr_reg(SLEEP_CFG_ADDR, 0);
    tick(2); chk(32'(pd_cfg), 2, "frozen");
    $display("test handover done");
    @(posedge clk) irq_in.pin <= 8'h01;
    tick(2); chk({31'b0, wake_req}, 0, "disabled pin");
    @(posedge clk) irq_in.pin <= 8'h02;
    tick(2); chk({31'b0, wake_req}, 1, "pin");
    @(posedge clk) irq_en.pin <= 8'hFD;
    tick(2); chk({31'b0, wake_req}, 0, "irq ctl off");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) irq_in <= 12'(4'b1000 >> k);
      tick(2); chk({31'b0, wake_req}, 1, "periph");
    end
    wr_reg(PERIPH_WAKE_ADDR, 32'h0008_0000);
    tick(2); chk({31'b0, wake_req}, 0, "periph off");
    @(posedge clk) clk_want <= 1'b1;
    catch_wake(1'b1, "rise");
    rd_reg(USB_STAT_ADDR, v); chk(v, 1, "status");
    @(posedge clk) clk_want <= 1'b0;
    catch_wake(1'b0, "fall ignored");
    wr_reg(USB_CTRL_ADDR, 0);
    @(posedge clk) {slow, clk_want} <= 2'b11;
    catch_wake(1'b0, "rise ignored");
    @(posedge clk) clk_want <= 1'b0;
    catch_wake(1'b1, "fall");
    wr_reg(USB_CTRL_ADDR, 1);
    tick(2); chk({31'b0, usb_clk_req}, 1, "override");
    rd_reg(USB_STAT_ADDR, v); chk(v, 1, "status forced");
    $display("test wake done");
    @(posedge clk) {sleep_want, irq_en.pin, irq_in.pin} <= {1'b0, 8'hFF, 8'h02};
    tick(3); chk({30'b0, afo, wake_req}, 0, "awake");
    chk(32'(pd_cfg), 0, "cfg tracks after exit");
    $display("test exit done");
    @(posedge clk) srst <= 1'b1;
    tick(2); chk({30'b0, usb_clk_req, wake_req}, 0, "outputs in reset");
    chk(32'(pd_cfg), 3, "cfg in reset");
    @(posedge clk) srst <= 1'b0;
    rd_reg(SLEEP_CFG_ADDR, v); chk(v, 32'h0000_007F, "sleep after reset");
    tick(1); chk(rdata, 0, "read data one cycle");
    rd_reg(USB_CTRL_ADDR, v); chk(v, 0, "ctrl after reset");
    rd_reg(PERIPH_WAKE_ADDR, v); chk(v, 0, "periph after reset");
    $display("test reset done");
    summarize();
  end
endmodule // tb_wakeup_source_power_config
